// ===== core/pinmux_cfg.svh
`ifndef PINMUX_CFG_SVH
`define PINMUX_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_A_ALT_ENABLE   8'h00
`define OFS_A_SET_ONE      8'h04
`define OFS_A_SET_TWO      8'h08
`define PORT_STRIDE        8'h0c
`define OFS_D_ALT_ENABLE   8'h24
`define OFS_E_ALT_ENABLE   8'h28
`define OFS_PKG_SELECT     8'h2c
`define OFS_ACTIVE_STATUS  8'h30
`define OFS_CHOICE_STATUS  8'h34
`define REG_COUNT          6'd14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ALT_ENABLE_RST     8'h00
`define SET_ONE_RST        8'h00
`define SET_TWO_RST        8'h00
`define PKG_SEL_RST        2'h2

// ----------------------------------------------------------------
// Usable choices per pin: V0 for select 0, V1 for select 1
// ----------------------------------------------------------------
`define A_V0_28            8'hff
`define A_V1_28            8'hc0
`define A_V0_40            8'hff
`define A_V1_40            8'h00
`define B_V0               8'h08
`define B_V1               8'h3f
`define C_V0_28            8'hfe
`define C_V0_40            8'hfc
`define C_V1               8'hff
`define D_MASK_28          8'h01
`define D_MASK_40          8'hff
`define E_MASK_28          8'h00
`define E_MASK_40          8'h06
`define E_MASK_44          8'h3f

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== core/pinmux_pkg.sv
package pinmux_pkg;

    // Package variant; each selects its own pin function map.
    typedef enum logic [1:0] {
        PKG_28,
        PKG_40,
        PKG_44
    } pkg_sel_t;

endpackage

// ===== core/port_alt_function_select.sv
// Functional notes
// - C line 0: select 1 analog/LED; 0 reserved
// - C line 1 gives SPI MISO (28-pin only) or analog/LED
// - C line 2 gives SPI SS or analog/LED
// - C lines 4, 5 give SPI MOSI/SCK or LED
// - C lines 6, 7 give timer 2 or LED
// - Ports D, E have no set register
// - Ports D, E enable activates single function
// - Set register two stored but never steers
// - Choice acts only when pin enable set
// - Wide-package PA0, PA1 timer 0; 1 reserved
// - Wide-package PA2, PA3 UART DE/CTS; 1 reserved
// - Wide-package PA4, PA5 UART/infrared data
// - Wide-package PA6, PA7 timer 1; 1 reserved
// - Wide-package PB0-PB2 analog/amplifier; 0 reserved
// - Wide-package PB3 clock input or analog
// - Footnoted timers reserved in 40-pin package
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`include "pinmux_cfg.svh"

module port_alt_function_select
    import pinmux_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // AXI4-Lite write address and data.
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response.
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Pin routing, ports A to C: handed over, and second choice.
    output logic [7:0]       port_a_alt_active,
    output logic [7:0]       port_a_alt_second,
    output logic [7:0]       port_b_alt_active,
    output logic [7:0]       port_b_alt_second,
    output logic [7:0]       port_c_alt_active,
    output logic [7:0]       port_c_alt_second,
    // Pin routing, ports D and E: single function only.
    output logic [7:0]       port_d_alt_active,
    output logic [7:0]       port_e_alt_active
);

    // ----------------------------------------------------------------
    // Default clocking for the checks below
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]  en_reg   [0:4];
    logic [7:0]  set1_reg [0:2];
    logic [7:0]  set2_reg [0:2];
    pkg_sel_t    pkg_reg;
    logic [39:0] act_reg;
    logic [23:0] sec_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic        w_strb0_reg;
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // ----------------------------------------------------------------
    // Write channel decode
    // ----------------------------------------------------------------
    // A write fires once address and data are held and B is idle.
    wire         do_wr   = !awready_reg && !wready_reg && !bvalid_reg;
    wire         wr_hit  = aw_addr_reg[7:2] < `REG_COUNT;
    wire         wr_lane = do_wr && w_strb0_reg;
    wire [4:0]   we_en;
    wire [2:0]   we_s1;
    wire [2:0]   we_s2;
    wire         we_pkg;
    genvar p;
    genvar i;
    generate
        for (p = 0; p < 3; p++) begin : g_wdec
            localparam logic [7:0] BASE =
                `OFS_A_ALT_ENABLE + 8'(p) * `PORT_STRIDE;
            assign we_en[p] = wr_lane && (aw_addr_reg == BASE);
            assign we_s1[p] = wr_lane &&
                (aw_addr_reg == BASE + `OFS_A_SET_ONE);
            assign we_s2[p] = wr_lane &&
                (aw_addr_reg == BASE + `OFS_A_SET_TWO);
        end
    endgenerate

    // Ports D and E have only an enable register, no set register.
    assign we_en[3] = wr_lane && (aw_addr_reg == `OFS_D_ALT_ENABLE);
    assign we_en[4] = wr_lane && (aw_addr_reg == `OFS_E_ALT_ENABLE);
    // Code 3 names no package, so such a write is dropped.
    assign we_pkg   = wr_lane && (aw_addr_reg == `OFS_PKG_SELECT) &&
                      (w_data_reg[1:0] != 2'h3);

    // ----------------------------------------------------------------
    // Function map per package
    // ----------------------------------------------------------------
    wire         is28 = (pkg_reg == PKG_28);
    wire         is40 = (pkg_reg == PKG_40);
    wire [7:0]   v0 [0:2];
    wire [7:0]   v1 [0:2];
    wire [7:0]   d_mask;
    wire [7:0]   e_mask;

    assign v0[0]  = is28 ? `A_V0_28 : `A_V0_40;
    assign v1[0]  = is28 ? `A_V1_28 : `A_V1_40;
    assign v0[1]  = `B_V0;
    assign v1[1]  = `B_V1;
    assign v0[2]  = is28 ? `C_V0_28 : `C_V0_40;
    assign v1[2]  = `C_V1;
    assign d_mask = is28 ? `D_MASK_28 : `D_MASK_40;
    // Timer pins of port E exist only in the largest package.
    assign e_mask = is28 ? `E_MASK_28 :
                    (is40 ? `E_MASK_40 : `E_MASK_44);

    // ----------------------------------------------------------------
    // Per-pin routing
    // ----------------------------------------------------------------
    // Set register two never steers: one bit picks between two choices.
    wire [39:0]  act_next;
    wire [23:0]  sec_next;
    generate
        for (p = 0; p < 3; p++) begin : g_port
            for (i = 0; i < 8; i++) begin : g_pin
                wire choose1 = set1_reg[p][i];
                wire usable  = choose1 ? v1[p][i] : v0[p][i];
                assign act_next[8*p+i] =
                    en_reg[p][i] && usable;
                assign sec_next[8*p+i] =
                    en_reg[p][i] && usable && choose1;
            end
        end
    endgenerate
    // The enable and the package mask hand a port D or E pin to its function.
    assign act_next[31:24] = en_reg[3] & d_mask;
    assign act_next[39:32] = en_reg[4] & e_mask;

    // One cycle of lag keeps every pin control glitch-free.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_reg <= 40'h0;
            sec_reg <= 24'h0;
        end else begin
            act_reg <= act_next;
            sec_reg <= sec_next;
        end
    end

    assign port_a_alt_active = act_reg[7:0];
    assign port_b_alt_active = act_reg[15:8];
    assign port_c_alt_active = act_reg[23:16];
    assign port_d_alt_active = act_reg[31:24];
    assign port_e_alt_active = act_reg[39:32];
    assign port_a_alt_second = sec_reg[7:0];
    assign port_b_alt_second = sec_reg[15:8];
    assign port_c_alt_second = sec_reg[23:16];

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 5; k++) begin
                en_reg[k] <= `ALT_ENABLE_RST;
            end
            for (int k = 0; k < 3; k++) begin
                set1_reg[k] <= `SET_ONE_RST;
                set2_reg[k] <= `SET_TWO_RST;
            end
            pkg_reg <= pkg_sel_t'(`PKG_SEL_RST);
        end else begin
            for (int k = 0; k < 5; k++) begin
                if (we_en[k]) begin
                    en_reg[k] <= w_data_reg[7:0];
                end
            end
            for (int k = 0; k < 3; k++) begin
                if (we_s1[k]) begin
                    set1_reg[k] <= w_data_reg[7:0];
                end
                if (we_s2[k]) begin
                    set2_reg[k] <= w_data_reg[7:0];
                end
            end
            if (we_pkg) begin
                pkg_reg <= pkg_sel_t'(w_data_reg[1:0]);
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    // Address and data are caught apart, so either may come first.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0;
            w_strb0_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `RESP_OKAY;
        end else begin
            if (awready_reg && s_axi_awvalid) begin
                awready_reg <= 1'b0;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (wready_reg && s_axi_wvalid) begin
                wready_reg  <= 1'b0;
                w_data_reg  <= s_axi_wdata;
                w_strb0_reg <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg  <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    wire [31:0]  rd_word [0:13];
    wire [5:0]   rd_idx = s_axi_araddr[7:2];
    wire         rd_hit = rd_idx < `REG_COUNT;
    wire [31:0]  rd_data = rd_hit ? rd_word[rd_idx[3:0]] : 32'h0;

    generate
        for (p = 0; p < 3; p++) begin : g_rd
            assign rd_word[3*p]   = {24'h0, en_reg[p]};
            assign rd_word[3*p+1] = {24'h0, set1_reg[p]};
            assign rd_word[3*p+2] = {24'h0, set2_reg[p]};
        end
    endgenerate

    assign rd_word[9]  = {24'h0, en_reg[3]};
    assign rd_word[10] = {24'h0, en_reg[4]};
    assign rd_word[11] = {30'h0, pkg_reg};
    // Status words show what each pin is really handed to.
    assign rd_word[12] = act_reg[31:0];
    assign rd_word[13] = {act_reg[39:32], sec_reg};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= `RESP_OKAY;
        end else if (arready_reg && s_axi_arvalid) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_data;
            rresp_reg   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_c_line0_map;
        is28 && en_reg[2][0] |=> port_c_alt_active[0] == $past(set1_reg[2][0]);
    endproperty
    a_c_line0_map: assert property (p_c_line0_map)
        else $error("Port C line 0 routing wrong.");
    property p_c_line1_map;
        is28 && en_reg[2][1] |=> port_c_alt_active[1] &&
            port_c_alt_second[1] == $past(set1_reg[2][1]);
    endproperty
    a_c_line1_map: assert property (p_c_line1_map)
        else $error("Port C line 1 routing wrong.");
    property p_c_line2_map;
        en_reg[2][2] |=> port_c_alt_active[2];
    endproperty
    a_c_line2_map: assert property (p_c_line2_map)
        else $error("Port C line 2 not handed over.");
    property p_c_upper_map;
        is28 && (en_reg[2][7:4] == 4'hf) |=>
            (port_c_alt_active[7:4] == 4'hf) &&
            (port_c_alt_second[7:4] == $past(set1_reg[2][7:4]));
    endproperty
    a_c_upper_map: assert property (p_c_upper_map)
        else $error("Port C lines 4 to 7 routing wrong.");
    property p_disabled;
        (en_reg[0] == 8'h00) ##1 (en_reg[0] == 8'h00) |->
            (port_a_alt_active == 8'h00) && (port_a_alt_second == 8'h00);
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("Port A pin active while disabled.");
    property p_pa_map;
        !is28 |=> port_a_alt_active == $past(en_reg[0] & ~set1_reg[0]);
    endproperty
    a_pa_map: assert property (p_pa_map)
        else $error("Port A wide-package routing wrong.");
    property p_pb_map;
        !is28 && en_reg[1][3] |=> port_b_alt_active[3] &&
            port_b_alt_second[3] == $past(set1_reg[1][3]);
    endproperty
    a_pb_map: assert property (p_pb_map)
        else $error("Port B line 3 routing wrong.");
    property p_pb_reserved;
        en_reg[1][0] && !set1_reg[1][0] |=> !port_b_alt_active[0];
    endproperty
    a_pb_reserved: assert property (p_pb_reserved)
        else $error("Reserved port B choice took the pin.");
    property p_pd_single;
        !is28 |=> port_d_alt_active == $past(en_reg[3]);
    endproperty
    a_pd_single: assert property (p_pd_single)
        else $error("Port D pin not following its enable.");
    property p_pe_timer;
        is40 && en_reg[4][0] |=> !port_e_alt_active[0];
    endproperty
    a_pe_timer: assert property (p_pe_timer)
        else $error("Timer pin active in smaller package.");
    property p_set_two;
        $changed(set2_reg[0]) && $stable(en_reg[0]) &&
            $stable(set1_reg[0]) && $stable(pkg_reg) |=>
            $stable(port_a_alt_active);
    endproperty
    a_set_two: assert property (p_set_two)
        else $error("Set register two changed routing.");

endmodule

// ===== testbench/pin_owner_model.sv
// ----------------------------------------------------------------
// Pin owner model
// ----------------------------------------------------------------
module pin_owner_model (
    // Routing flags from the selector.
    input  wire logic [7:0]  alt_active,
    input  wire logic [7:0]  alt_second,
    // Owner per pin: 0 port logic, 1 first, 2 second function.
    output logic      [15:0] owner
);
    timeunit 1ns;
    timeprecision 1ps;

    // An inactive pin stays with the port logic whatever its choice bit.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            owner[2*i +: 2] = !alt_active[i] ? 2'h0 :
                              (alt_second[i] ? 2'h2 : 2'h1);
        end
    end
endmodule

// ===== testbench/port_alt_function_select_tb_top.sv
`include "pinmux_cfg.svh"

module port_alt_function_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        core_clk, rst_n;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp, pkg_q;
    logic [7:0]  a_act, a_sec, b_act, b_sec, c_act, c_sec, d_act, e_act;
    logic [7:0]  en_q [5];
    logic [7:0]  set1_q [3];
    logic [15:0] owner_c;
    int          num_errors, checked, cycles;

    port_alt_function_select dut_u (
        .core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .port_a_alt_active(a_act), .port_a_alt_second(a_sec),
        .port_b_alt_active(b_act), .port_b_alt_second(b_sec),
        .port_c_alt_active(c_act), .port_c_alt_second(c_sec),
        .port_d_alt_active(d_act), .port_e_alt_active(e_act)
    );

    pin_owner_model owner_u (
        .alt_active(c_act), .alt_second(c_sec), .owner(owner_c)
    );

    always #4 core_clk = ~core_clk;

    // The ceiling is about twenty times the expected run length.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // Checks and expectations
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("Checks made %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_pin(string n, logic [7:0] e, logic [7:0] g);
        chk_val(n, {24'h0, e}, {24'h0, g});
    endtask

    task automatic chk_resp(string n, logic [1:0] e, logic [1:0] g);
        chk_val(n, {30'h0, e}, {30'h0, g});
    endtask

    function automatic logic [7:0] pick(logic [7:0] en, s, v0, v1);
        return en & ((s & v1) | (~s & v0));
    endfunction

    // Expected handed-over pins of port p for the current settings.
    function automatic logic [7:0] exp_act(int p);
        logic n;
        n = (pkg_q == 2'h0);
        case (p)
            0: return pick(en_q[0], set1_q[0], n ? `A_V0_28 : `A_V0_40,
                           n ? `A_V1_28 : `A_V1_40);
            1: return pick(en_q[1], set1_q[1], `B_V0, `B_V1);
            2: return pick(en_q[2], set1_q[2], n ? `C_V0_28 : `C_V0_40,
                           `C_V1);
            3: return en_q[3] & (n ? `D_MASK_28 : `D_MASK_40);
            default: return en_q[4] & (n ? `E_MASK_28 :
                            (pkg_q == 2'h1 ? `E_MASK_40 : `E_MASK_44));
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Bus master tasks
    // ----------------------------------------------------------------
    // Ready is registered, so it is read at the falling edge and the
    // channel is released by the following rising edge.
    task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        logic aw_done, w_done, b_take;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge core_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge core_clk);
            if (s_axi_awvalid && s_axi_awready) aw_done = 1'b1;
            if (s_axi_wvalid && s_axi_wready) w_done = 1'b1;
            @(posedge core_clk);
            if (aw_done) s_axi_awvalid <= 1'b0;
            if (w_done) s_axi_wvalid <= 1'b0;
        end
        do begin
            @(negedge core_clk);
            b_take = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge core_clk);
        end while (!b_take);
        s_axi_bready <= 1'b0;
        chk_resp("write response", er, resp);
    endtask

    task automatic axi_rd(logic [7:0] a);
        logic ar_done, r_take;
        ar_done = 1'b0;
        @(posedge core_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        while (!ar_done) begin
            @(negedge core_clk);
            ar_done = s_axi_arready;
            @(posedge core_clk);
        end
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge core_clk);
            r_take = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge core_clk);
        end while (!r_take);
        s_axi_rready <= 1'b0;
    endtask

    task automatic check_outputs();
        logic [7:0] c;
        c = exp_act(2);
        chk_pin("a active", exp_act(0), a_act);
        chk_pin("a second", exp_act(0) & set1_q[0], a_sec);
        chk_pin("b active", exp_act(1), b_act);
        chk_pin("b second", exp_act(1) & set1_q[1], b_sec);
        chk_pin("c active", c, c_act);
        chk_pin("c second", c & set1_q[2], c_sec);
        chk_pin("d active", exp_act(3), d_act);
        chk_pin("e active", exp_act(4), e_act);
        chk_resp("c line 0 owner", c[0] ? (set1_q[2][0] ? 2'h2 : 2'h1) :
                 2'h0, owner_c[1:0]);
        axi_rd(8'h30);
        chk_val("active status", {exp_act(3), c, exp_act(1), exp_act(0)},
                rd);
        axi_rd(8'h34);
        chk_val("choice status", {exp_act(4), c & set1_q[2],
                exp_act(1) & set1_q[1], exp_act(0) & set1_q[0]}, rd);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        num_errors = 0;
        checked = 0;
        cycles = 0;
        void'($urandom(32'hbdf6));
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        // Every writable register starts cleared, package select wide.
        for (int i = 0; i < 12; i++) begin
            axi_rd(8'(i * 4));
            chk_val("reset value", (i == 11) ? {30'h0, `PKG_SEL_RST} :
                    {24'h0, `ALT_ENABLE_RST}, rd);
        end
        axi_wr(8'h38, 32'hff, `RESP_SLVERR);
        axi_rd(8'h38);
        chk_resp("unmapped read", `RESP_SLVERR, resp);
        chk_val("unmapped data", 32'h0, rd);
        // A write with byte lane 0 switched off still answers but stores
        // nothing.
        s_axi_wstrb <= 4'he;
        axi_wr(8'h00, 32'h5a, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi_rd(8'h00);
        chk_val("lane off", {24'h0, `ALT_ENABLE_RST}, rd);
        // Each package with corner patterns first, then random ones.
        for (int k = 0; k < 3; k++) begin
            pkg_q = 2'(k);
            axi_wr(8'h2c, {30'h0, pkg_q}, `RESP_OKAY);
            axi_wr(8'h2c, 32'h3, `RESP_OKAY);
            axi_rd(8'h2c);
            chk_val("package", {30'h0, pkg_q}, rd);
            for (int it = 0; it < 12; it++) begin
                for (int p = 0; p < 5; p++)
                    en_q[p] = (it < 2) ? 8'hff : 8'($urandom);
                for (int p = 0; p < 3; p++) begin
                    set1_q[p] = (it == 0) ? 8'h00 :
                                (it == 1) ? 8'hff : 8'($urandom);
                    axi_wr(8'(p * 12), {24'h0, en_q[p]}, `RESP_OKAY);
                    axi_wr(8'(p * 12 + 4), {24'h0, set1_q[p]}, `RESP_OKAY);
                    axi_wr(8'(p * 12 + 8), $urandom, `RESP_OKAY);
                end
                axi_wr(8'h24, {24'h0, en_q[3]}, `RESP_OKAY);
                axi_wr(8'h28, {24'h0, en_q[4]}, `RESP_OKAY);
                repeat (3) @(posedge core_clk);
                @(negedge core_clk);
                check_outputs();
            end
        end
        stop_test();
    end
endmodule
